// ---- logic/apc_regs.vh ----
// register offsets, field positions and reset values of the analog path control bank
// assumes a word-addressed plain register port, one 16-bit register per address
`ifndef APC_REGS_VH
`define APC_REGS_VH
// register indices
`define APC_JACK_DETECT_ENABLES 8'h4d
`define APC_POP_SUPPRESSION_CONTROL 8'h4e
`define APC_LEFT_INPUT_GAIN 8'h50
`define APC_RIGHT_INPUT_GAIN 8'h51
`define APC_LEFT_OUTPUT_MIXER_SELECT 8'h58
`define APC_RIGHT_OUTPUT_MIXER_SELECT 8'h59
`define APC_MONO_C_MIXER_SELECT 8'h5c
`define APC_MONO_D_MIXER_SELECT 8'h5d
`define APC_LEFT_OUTPUT_MIXER_GAINS 8'h60
`define APC_RIGHT_OUTPUT_MIXER_GAINS 8'h61
`define APC_LEFT_INPUT_MIXER_GAINS 8'h62
`define APC_RIGHT_INPUT_MIXER_GAINS 8'h63
`define APC_MONO_D_FEEDBACK_ROUTE 8'h64
`define APC_PAIR_A_LEFT_OUTPUT_GAIN 8'h68
// writable bit masks, undefined bits read zero
`define APC_MASK_JACK 16'hc000
`define APC_MASK_POP 16'h03ff
`define APC_MASK_IN_GAIN 16'he0fc
`define APC_MASK_LEFT_MIX 16'h9807
`define APC_MASK_RIGHT_MIX 16'h980b
`define APC_MASK_MONO_C 16'h8909
`define APC_MASK_MONO_D 16'h9e07
`define APC_MASK_LEFT_MIX_GAIN 16'h0eee
`define APC_MASK_RIGHT_MIX_GAIN 16'he0ee
`define APC_MASK_LEFT_IN_MIX_GAIN 16'h0e0f
`define APC_MASK_RIGHT_IN_MIX_GAIN 16'he0e1
`define APC_MASK_FEEDBACK 16'h800e
`define APC_MASK_PAIR_A 16'he0fc
// reset values
`define APC_RST_ZERO 16'h0000
`define APC_RST_IN_GAIN 16'h0040
`define APC_RST_LEFT_MIX 16'h0800
`define APC_RST_RIGHT_MIX 16'h1000
`define APC_RST_PAIR_A 16'h00e4
// field positions
`define APC_BIT_ON 15
`define APC_BIT_SILENCE 14
`define APC_BIT_ZERO_CROSS 13
`define APC_BIT_COMMIT 8
`define APC_GAIN_HI 7
`define APC_GAIN_LO 2
`define APC_GAIN_RST 6'h10
`define APC_BIT_MONO_D_ATTEN 10
`define APC_BIT_MONO_C_INTO_D 2
`endif

// ---- logic/apc_analog_path_control_regs.v ----
// analog path control register bank: 16-bit control words steering codec routing
// assumes a synchronous plain register port and zero-cross strobes from the analog side
//
// The plain strobed port is this design's own decision.
`include "apc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module apc_analog_path_control_regs #(
   parameter ADDR_WIDTH = 8,
   parameter DATA_WIDTH = 16
) (
   // clock and asynchronous reset
   input wire clk,
   input wire rst_n,
   // plain register port from software
   input wire [ADDR_WIDTH-1:0] regAddr,
   input wire [DATA_WIDTH-1:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [DATA_WIDTH-1:0] regRdData,
   output reg regRdValid,
   // zero-cross strobes from the analog side
   input wire leftZeroCross,
   input wire rightZeroCross,
   // masked register copies for the analog controls
   output reg [DATA_WIDTH-1:0] jackDetectEnables,
   output reg [DATA_WIDTH-1:0] popSuppressionControl,
   output reg [DATA_WIDTH-1:0] leftOutputMixerSelect,
   output reg [DATA_WIDTH-1:0] rightOutputMixerSelect,
   output reg [DATA_WIDTH-1:0] monoCMixerSelect,
   output reg [DATA_WIDTH-1:0] monoDMixerSelect,
   output reg [DATA_WIDTH-1:0] leftOutputMixerGains,
   output reg [DATA_WIDTH-1:0] rightOutputMixerGains,
   output reg [DATA_WIDTH-1:0] leftInputMixerGains,
   output reg [DATA_WIDTH-1:0] rightInputMixerGains,
   output reg [DATA_WIDTH-1:0] monoDFeedbackRoute,
   output reg [DATA_WIDTH-1:0] pairALeftOutputGain,
   // live input stage controls
   output reg leftGainStageOn,
   output reg rightGainStageOn,
   output reg leftGainStagePass,
   output reg rightGainStagePass,
   // gain in force and commit state per side
   output reg [5:0] leftGainApplied,
   output reg [5:0] rightGainApplied,
   output reg leftGainPending,
   output reg rightGainPending
);

   // software copies of the input gain registers
   reg [DATA_WIDTH-1:0] leftInputGain;
   reg [DATA_WIDTH-1:0] rightInputGain;
   // target is loaded by a commit, applied by the timing rule
   // committed gain waiting for its moment
   reg [5:0] leftGainTarget;
   reg [5:0] rightGainTarget;
   // selected by index, registered before it leaves
   // combinational read word
   reg [DATA_WIDTH-1:0] readWord;
   // both gain words share one commit
   // write decode helpers
   wire wrLeftGain;
   wire wrRightGain;
   wire commitNow;

   // used on every write so reserved bits always read zero
   // masked store: only defined bits survive
   function [15:0] keepDefined;
      input [15:0] data;
      input [15:0] mask;
      begin
         keepDefined = data & mask;
      end
   endfunction

   // kept as a guard even though the masks already drop bit 8
   // commit bit reads back as zero, it is an action
   function [15:0] readGain;
      input [15:0] word;
      begin
         readGain = word & ~(16'h0001 << `APC_BIT_COMMIT);
      end
   endfunction

   // write decode, one strobe per input gain word
   assign wrLeftGain = regWrite && (regAddr == `APC_LEFT_INPUT_GAIN);
   assign wrRightGain = regWrite && (regAddr == `APC_RIGHT_INPUT_GAIN);
   // either input gain word may carry the commit bit
   // shared commit
   assign commitNow = (wrLeftGain || wrRightGain) && regWrData[`APC_BIT_COMMIT];

   // holds every word that needs no timing rule
   // plain control registers, load on write
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // reserved bits and most fields power up cleared
         // reset defaults
         jackDetectEnables <= `APC_RST_ZERO;
         popSuppressionControl <= `APC_RST_ZERO;
         // each output mixer starts with its own converter
         leftOutputMixerSelect <= `APC_RST_LEFT_MIX;
         rightOutputMixerSelect <= `APC_RST_RIGHT_MIX;
         monoCMixerSelect <= `APC_RST_ZERO;
         monoDMixerSelect <= `APC_RST_ZERO;
         leftOutputMixerGains <= `APC_RST_ZERO;
         rightOutputMixerGains <= `APC_RST_ZERO;
         leftInputMixerGains <= `APC_RST_ZERO;
         rightInputMixerGains <= `APC_RST_ZERO;
         monoDFeedbackRoute <= `APC_RST_ZERO;
         // pair a gain starts at 0 dB, code 111001
         pairALeftOutputGain <= `APC_RST_PAIR_A;
      end else if (regWrite) begin
         // only a write strobe touches the bank
         case (regAddr)
            // two sense enables, bits 15 and 14
            // right jack sense
            `APC_JACK_DETECT_ENABLES: begin
               jackDetectEnables <= keepDefined(regWrData, `APC_MASK_JACK);
            end
            // ramp speed and four discharge rates
            // ramp speed
            `APC_POP_SUPPRESSION_CONTROL: begin
               popSuppressionControl <= keepDefined(regWrData, `APC_MASK_POP);
            end
            // enable plus five source selects
            // left mixer selects
            `APC_LEFT_OUTPUT_MIXER_SELECT: begin
               leftOutputMixerSelect <= keepDefined(regWrData, `APC_MASK_LEFT_MIX);
            end
            // enable plus five source selects
            // right mixer selects
            `APC_RIGHT_OUTPUT_MIXER_SELECT: begin
               rightOutputMixerSelect <= keepDefined(regWrData, `APC_MASK_RIGHT_MIX);
            end
            // output enable plus four source enables
            // mono c sources
            `APC_MONO_C_MIXER_SELECT: begin
               monoCMixerSelect <= keepDefined(regWrData, `APC_MASK_MONO_C);
            end
            // enable, attenuate and six source enables
            // mono d sources
            `APC_MONO_D_MIXER_SELECT: begin
               monoDMixerSelect <= keepDefined(regWrData, `APC_MASK_MONO_D);
            end
            // three 3-bit path gains, 000 cuts the path
            // path gains stored raw
            `APC_LEFT_OUTPUT_MIXER_GAINS: begin
               leftOutputMixerGains <= keepDefined(regWrData, `APC_MASK_LEFT_MIX_GAIN);
            end
            // three 3-bit path gains in the right word
            // right mixer gain fields
            `APC_RIGHT_OUTPUT_MIXER_GAINS: begin
               rightOutputMixerGains <= keepDefined(regWrData, `APC_MASK_RIGHT_MIX_GAIN);
            end
            // two path gains and the boost bit
            // left record gains
            `APC_LEFT_INPUT_MIXER_GAINS: begin
               leftInputMixerGains <= keepDefined(regWrData, `APC_MASK_LEFT_IN_MIX_GAIN);
            end
            // two path gains and the boost bit
            // right record gains
            `APC_RIGHT_INPUT_MIXER_GAINS: begin
               rightInputMixerGains <= keepDefined(regWrData, `APC_MASK_RIGHT_IN_MIX_GAIN);
            end
            // destination bit and one 3-bit gain
            // feedback route
            `APC_MONO_D_FEEDBACK_ROUTE: begin
               monoDFeedbackRoute <= keepDefined(regWrData, `APC_MASK_FEEDBACK);
            end
            // enable, mute, zero-cross and gain, stored only
            `APC_PAIR_A_LEFT_OUTPUT_GAIN: begin
               pairALeftOutputGain <= keepDefined(regWrData, `APC_MASK_PAIR_A);
            end
            // the input gain words live in their own process
            // other addresses write nothing
            default: begin
            end
         endcase
      end
   end

   // input gain registers, commit bit is not stored
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // gain field resets to 010000, all flags clear
         // gain reset 0 dB
         leftInputGain <= `APC_RST_IN_GAIN;
         rightInputGain <= `APC_RST_IN_GAIN;
      end else begin
         // undefined bits and the commit bit are dropped here
         // enable, mute, zero-cross stored
         if (wrLeftGain) begin
            leftInputGain <= readGain(keepDefined(regWrData, `APC_MASK_IN_GAIN));
         end
         if (wrRightGain) begin
            rightInputGain <= readGain(keepDefined(regWrData, `APC_MASK_IN_GAIN));
         end
      end
   end

   // live stage controls follow the register one cycle later
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // every stage starts disabled
         leftGainStageOn <= 1'b0;
         rightGainStageOn <= 1'b0;
         leftGainStagePass <= 1'b0;
         rightGainStagePass <= 1'b0;
      end else begin
         // one cycle behind the stored word
         // amplifier enables
         leftGainStageOn <= leftInputGain[`APC_BIT_ON];
         rightGainStageOn <= rightInputGain[`APC_BIT_ON];
         // a disabled stage never passes, muted or not
         // mute cuts path to record mixer
         leftGainStagePass <= leftInputGain[`APC_BIT_ON] & ~leftInputGain[`APC_BIT_SILENCE];
         rightGainStagePass <= rightInputGain[`APC_BIT_ON] & ~rightInputGain[`APC_BIT_SILENCE];
      end
   end

   // left committed gain: immediate or at zero crossing
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // applied gain starts at 0 dB, nothing pending
         leftGainTarget <= `APC_GAIN_RST;
         leftGainApplied <= `APC_GAIN_RST;
         leftGainPending <= 1'b0;
      end else if (commitNow) begin
         // a new commit while pending replaces the target
         // a crossing in the commit cycle is ignored
         // the side not written latches its stored value
         // a commit written with the left word uses the new left value
         if (wrLeftGain) begin
            leftGainTarget <= regWrData[`APC_GAIN_HI:`APC_GAIN_LO];
         end else begin
            leftGainTarget <= leftInputGain[`APC_GAIN_HI:`APC_GAIN_LO];
         end
         leftGainPending <= 1'b1;
      end else if (leftGainPending) begin
         // timing mode is read from the stored word
         // zero-cross timing select
         if (!leftInputGain[`APC_BIT_ZERO_CROSS] || leftZeroCross) begin
            leftGainApplied <= leftGainTarget;
            leftGainPending <= 1'b0;
         end
      end
   end

   // right committed gain: same scheme as left
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // applied gain starts at 0 dB, nothing pending
         rightGainTarget <= `APC_GAIN_RST;
         rightGainApplied <= `APC_GAIN_RST;
         rightGainPending <= 1'b0;
      end else if (commitNow) begin
         // same replace and ignore rules as the left side
         // the side written now takes its gain from the bus
         // shared commit
         if (wrRightGain) begin
            rightGainTarget <= regWrData[`APC_GAIN_HI:`APC_GAIN_LO];
         end else begin
            rightGainTarget <= rightInputGain[`APC_GAIN_HI:`APC_GAIN_LO];
         end
         rightGainPending <= 1'b1;
      end else if (rightGainPending) begin
         // timing mode is read from the stored word
         // zero-cross timing select
         if (!rightInputGain[`APC_BIT_ZERO_CROSS] || rightZeroCross) begin
            rightGainApplied <= rightGainTarget;
            rightGainPending <= 1'b0;
         end
      end
   end

   // holes between registers also read zero
   // read mux, unmapped reads zero
   always @* begin
      case (regAddr)
         // jack sense and pop suppression
         `APC_JACK_DETECT_ENABLES: readWord = jackDetectEnables;
         `APC_POP_SUPPRESSION_CONTROL: readWord = popSuppressionControl;
         // input gain words, commit bit never stored
         `APC_LEFT_INPUT_GAIN: readWord = leftInputGain;
         `APC_RIGHT_INPUT_GAIN: readWord = rightInputGain;
         // source selects
         `APC_LEFT_OUTPUT_MIXER_SELECT: readWord = leftOutputMixerSelect;
         `APC_RIGHT_OUTPUT_MIXER_SELECT: readWord = rightOutputMixerSelect;
         `APC_MONO_C_MIXER_SELECT: readWord = monoCMixerSelect;
         `APC_MONO_D_MIXER_SELECT: readWord = monoDMixerSelect;
         // path gains and feedback route
         `APC_LEFT_OUTPUT_MIXER_GAINS: readWord = leftOutputMixerGains;
         `APC_RIGHT_OUTPUT_MIXER_GAINS: readWord = rightOutputMixerGains;
         `APC_LEFT_INPUT_MIXER_GAINS: readWord = leftInputMixerGains;
         `APC_RIGHT_INPUT_MIXER_GAINS: readWord = rightInputMixerGains;
         `APC_MONO_D_FEEDBACK_ROUTE: readWord = monoDFeedbackRoute;
         // pair a gain word
         `APC_PAIR_A_LEFT_OUTPUT_GAIN: readWord = pairALeftOutputGain;
         // unmapped index
         default: readWord = 16'h0000;
      endcase
   end

   // read data register, one cycle after strobe, zero otherwise
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // quiet bus during reset
         regRdData <= 16'h0000;
         regRdValid <= 1'b0;
      end else begin
         // undefined bits read zero
         // zero outside the answer cycle keeps the bus quiet
         regRdData <= regRead ? readWord : 16'h0000;
         // valid marks the single answer cycle
         regRdValid <= regRead;
      end
   end

endmodule // apc_analog_path_control_regs
`default_nettype wire

// ---- dv/apc_regs_chk.sv ----
// checker for the analog path control bank: register port timing and gain commit
// assumes binding onto apc_analog_path_control_regs, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module apc_regs_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [15:0] regRdData,
   input wire logic regRdValid,
   input wire logic [15:0] jackDetectEnables,
   input wire logic [15:0] popSuppressionControl,
   input wire logic leftGainStageOn,
   input wire logic leftGainStagePass,
   input wire logic [5:0] leftGainApplied,
   input wire logic leftGainPending,
   input wire logic rightGainPending
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_read_answer_pulse: assert property (regRead |=> regRdValid)
      else $error("read strobe gave no valid pulse");
   a_idle_read_zero: assert property (!regRead |=> !regRdValid && regRdData == 16'h0000)
      else $error("read data outside the answer cycle");
   a_jack_write_mask: assert property (
      regWrite && regAddr == 8'h4d |=> jackDetectEnables == ($past(regWrData) & 16'hc000))
      else $error("jack sense word wrong after write");
   a_pop_write_mask: assert property (
      regWrite && regAddr == 8'h4e |=> popSuppressionControl == ($past(regWrData) & 16'h03ff))
      else $error("pop control word wrong after write");
   a_stage_on_follow: assert property (
      regWrite && regAddr == 8'h50 |=> ##1 leftGainStageOn == $past(regWrData[15], 2))
      else $error("left stage enable not following bit 15");
   a_stage_pass_mute: assert property (
      regWrite && regAddr == 8'h50 |=> ##1
      leftGainStagePass == ($past(regWrData[15], 2) && !$past(regWrData[14], 2)))
      else $error("left stage path not cut by silence");
   a_gain_held_idle: assert property (!leftGainPending |=> $stable(leftGainApplied))
      else $error("left gain moved without a commit");
   a_commit_sets_pending: assert property (
      regWrite && (regAddr == 8'h50 || regAddr == 8'h51) && regWrData[8]
      |=> leftGainPending && rightGainPending)
      else $error("commit did not mark both sides pending");
   a_direct_gain_apply: assert property (
      regWrite && regAddr == 8'h50 && regWrData[8] && !regWrData[13]
      ##1 !(regWrite && regWrData[8] && (regAddr == 8'h50 || regAddr == 8'h51))
      |=> leftGainApplied == $past(regWrData[7:2], 2) && !leftGainPending)
      else $error("direct commit not applied two cycles on");
   cover property (regRead && regAddr == 8'h4f);
   cover property (leftGainPending ##1 !leftGainPending);
   cover property (leftGainStagePass);
endmodule // apc_regs_chk
bind apc_analog_path_control_regs apc_regs_chk apc_regs_chk_inst (.clk(clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .regRdValid(regRdValid), .jackDetectEnables(jackDetectEnables),
   .popSuppressionControl(popSuppressionControl), .leftGainStageOn(leftGainStageOn),
   .leftGainStagePass(leftGainStagePass), .leftGainApplied(leftGainApplied),
   .leftGainPending(leftGainPending), .rightGainPending(rightGainPending));
`default_nettype wire

// ---- dv/apc_analog_path_control_regs_tb_top.sv ----
// testbench for the analog path control bank
// assumes the checker is bound in; the bench drives the register port itself
`timescale 1ns/1ps
`default_nettype none
module apc_analog_path_control_regs_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic leftZeroCross = 1'b0;
   logic rightZeroCross = 1'b0;
   wire [15:0] regRdData;
   wire [5:0] leftGainApplied, rightGainApplied;
   wire leftGainStageOn, leftGainStagePass, leftGainPending;
   wire regRdValid;
   wire rightGainStageOn, rightGainStagePass, rightGainPending;
   // register copies in index order, input gain words left out
   wire [15:0] regCopy [12];
   int errors = 0;
   int testsRun = 0;
   int cycles = 0;
   // register index, reset value and writable bits
   logic [7:0] idx [14] = '{8'h4d, 8'h4e, 8'h50, 8'h51, 8'h58, 8'h59, 8'h5c, 8'h5d, 8'h60,
      8'h61, 8'h62, 8'h63, 8'h64, 8'h68};
   logic [15:0] rstv [14] = '{16'h0000, 16'h0000, 16'h0040, 16'h0040, 16'h0800, 16'h1000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00e4};
   logic [15:0] mask [14] = '{16'hc000, 16'h03ff, 16'he0fc, 16'he0fc, 16'h9807, 16'h980b,
      16'h8909, 16'h9e07, 16'h0eee, 16'he0ee, 16'h0e0f, 16'he0e1, 16'h800e, 16'he0fc};
   apc_analog_path_control_regs apc_analog_path_control_regs_inst (.clk(clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .regRdValid(regRdValid), .leftZeroCross(leftZeroCross),
      .rightZeroCross(rightZeroCross), .jackDetectEnables(regCopy[0]),
      .popSuppressionControl(regCopy[1]), .leftOutputMixerSelect(regCopy[2]),
      .rightOutputMixerSelect(regCopy[3]), .monoCMixerSelect(regCopy[4]),
      .monoDMixerSelect(regCopy[5]), .leftOutputMixerGains(regCopy[6]),
      .rightOutputMixerGains(regCopy[7]), .leftInputMixerGains(regCopy[8]),
      .rightInputMixerGains(regCopy[9]), .monoDFeedbackRoute(regCopy[10]),
      .pairALeftOutputGain(regCopy[11]), .leftGainStageOn(leftGainStageOn),
      .rightGainStageOn(rightGainStageOn), .leftGainStagePass(leftGainStagePass),
      .rightGainStagePass(rightGainStagePass), .leftGainApplied(leftGainApplied),
      .rightGainApplied(rightGainApplied), .leftGainPending(leftGainPending),
      .rightGainPending(rightGainPending));
   always #10 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (errors == 0 && testsRun > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      testsRun++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   // one-cycle read strobe, data judged in the next cycle
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(regRdData, exp);
      chk(16'(regRdValid), 16'h0001);
   endtask
   task automatic t_defaults();
      for (int i = 0; i < 14; i++) begin
         rd(idx[i], rstv[i]);
         if (i < 2 || i > 3) chk(regCopy[(i < 2) ? i : i - 2], rstv[i]);
      end
      rd(8'h4f, 16'h0000);
      chk(16'({leftGainPending, leftGainApplied}), 16'h0010);
      chk(16'({rightGainPending, rightGainApplied}), 16'h0010);
   endtask
   // field layout, plus two mixed ramp and discharge patterns
   task automatic t_fields();
      logic [15:0] d;
      for (int i = 0; i < 14; i++) begin
         d = (idx[i] == 8'h5d) ? 16'hfffb : 16'hffff;
         wr(idx[i], d);
         rd(idx[i], mask[i] & d);
         if (i < 2 || i > 3) chk(regCopy[(i < 2) ? i : i - 2], mask[i] & d);
         wr(idx[i], 16'h0000);
         rd(idx[i], 16'h0000);
      end
      wr(8'h4e, 16'h01e4);
      rd(8'h4e, 16'h01e4);
      wr(8'h4e, 16'h021b);
      rd(8'h4e, 16'h021b);
      wr(8'h4f, 16'hffff);
      rd(8'h4f, 16'h0000);
   endtask
   task automatic t_gain();
      wr(8'h51, 16'h0080);
      repeat (2) @(posedge clk);
      #1 chk(16'(rightGainApplied), 16'h0010);
      wr(8'h50, 16'h0100);
      repeat (2) @(posedge clk);
      #1 chk(16'(rightGainApplied), 16'h0020);
      chk(16'(leftGainApplied), 16'h0000);
   endtask
   task automatic t_zc();
      wr(8'h51, 16'h2000);
      wr(8'h50, 16'h21fc);
      repeat (4) @(posedge clk);
      #1 chk(16'({leftGainPending, leftGainApplied}), 16'h0040);
      chk(16'({rightGainPending, rightGainApplied}), 16'h0060);
      @(posedge clk);
      leftZeroCross <= 1'b1;
      rightZeroCross <= 1'b1;
      @(posedge clk);
      leftZeroCross <= 1'b0;
      rightZeroCross <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(16'({leftGainPending, leftGainApplied}), 16'h003f);
      chk(16'({rightGainPending, rightGainApplied}), 16'h0000);
   endtask
   task automatic t_stage();
      wr(8'h50, 16'hc000);
      repeat (2) @(posedge clk);
      #1 chk(16'({leftGainStageOn, leftGainStagePass}), 16'h0002);
      wr(8'h50, 16'h8000);
      repeat (2) @(posedge clk);
      #1 chk(16'({leftGainStageOn, leftGainStagePass}), 16'h0003);
      wr(8'h51, 16'hc000);
      repeat (2) @(posedge clk);
      #1 chk(16'({rightGainStageOn, rightGainStagePass}), 16'h0002);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_defaults();
      t_gain();
      t_zc();
      t_stage();
      t_fields();
      // second reset in mid-run
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      t_defaults();
      wrap_up();
   end
endmodule // apc_analog_path_control_regs_tb_top
`default_nettype wire
